// file: src/dpm_pkg.sv
// Shared constants and types of the host command block.
package dpm_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int WD_TICK_MS = 10;
	localparam int WD_TICK_CYCLES = WD_TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RESET_TIME_MS = 5;
	localparam int RESET_CYCLES = RESET_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ****************************************************************
	// Watchdog and addressing
	// ****************************************************************
	localparam int WD_TIMEOUT_W = 16;
	localparam logic [WD_TIMEOUT_W-1:0] WD_DISABLE = 16'h0000;
	localparam int STATION_W = 7;
	localparam logic [STATION_W-1:0] STATION_MIN = 7'h03;
	localparam logic [STATION_W-1:0] STATION_MAX = 7'h7b;
	localparam int BUF_BYTES_DEF = 256;

	// ****************************************************************
	// Result codes
	// ****************************************************************
	localparam int RES_W = 9;
	localparam logic [RES_W-1:0] RES_OK = 9'h000;
	localparam logic [RES_W-1:0] RES_TIMEOUT = 9'h001;
	localparam logic [RES_W-1:0] RES_BUS_CFG = 9'h064;
	localparam logic [RES_W-1:0] RES_CONS = 9'h065;
	localparam logic [RES_W-1:0] RES_SIZE = 9'h066;
	localparam logic [RES_W-1:0] RES_NO_SEM = 9'h100;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		NO_CMD,
		ARM_WATCHDOG_CMD,
		KICK_WATCHDOG_CMD,
		MASTER_ONLY_RESET_CMD,
		FULL_MODULE_RESET_CMD,
		WRITE_OUTPUT_BYTE_CMD,
		WRITE_OUTPUT_WORD_CMD,
		WRITE_OUTPUT_BLOCK_CMD,
		SET_MODE_CMD
	} dpm_cmd_t;
	typedef enum logic [1:0] {MODE_CLEAR, MODE_STOP, MODE_OPERATE, MODE_SYNC} dpm_mode_t;
	typedef enum logic {WITHOUT_CONSISTENCY, WITH_CONSISTENCY} dpm_cons_t;
	typedef enum logic [2:0] {MS_STOP, MS_CLEAR, MS_OPERATE, MS_RESET, MS_HALTED} dpm_mstate_t;
	typedef enum logic [1:0] {ST_IDLE, ST_BLOCK, ST_RESET} dpm_ctl_t;

endpackage

// file: src/dpm_wdog.sv
// Host watchdog with its 10 ms tick generator.
module dpm_wdog import dpm_pkg::*; #(
	parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
	input wire logic clk, // Module clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic arm, // Arming pulse.
	input wire logic [WD_TIMEOUT_W-1:0] timeout, // Interval in ticks.
	input wire logic kick, // Retrigger pulse.
	input wire logic clr, // Master reset pulse.
	output logic enabled, // Watchdog is running.
	output logic expired // Interval elapsed, sticky.
);
	localparam int DIV_W = $clog2(TICK_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1) begin : g_chk
		$error("TICK_CYCLES must be at least one");
	end

	logic [DIV_W-1:0] div_reg, div_next;
	logic [WD_TIMEOUT_W-1:0] cnt_reg, cnt_next, load_reg, load_next;
	logic en_reg, en_next, exp_reg, exp_next;

	always_comb begin
		div_next = div_reg;
		cnt_next = cnt_reg;
		load_next = load_reg;
		en_next = en_reg;
		exp_next = exp_reg;
		if (clr) begin
			div_next = '0;
			cnt_next = '0;
			en_next = 1'b0;
			exp_next = 1'b0;
		end else if (arm) begin
			load_next = timeout; // [R01]
			cnt_next = timeout;
			div_next = '0;
			en_next = (timeout != WD_DISABLE); // [R02]
		end else if (kick && en_reg && !exp_reg) begin
			cnt_next = load_reg; // [R20]
			div_next = '0;
		end else if (en_reg && !exp_reg) begin
			// The host has to kick before the count runs out. [R03]
			if (div_reg == DIV_LAST) begin
				div_next = '0; // [R20]
				if (cnt_reg == 16'h0001) begin
					exp_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end else begin
				div_next = div_reg + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			div_reg <= '0;
			cnt_reg <= '0;
			load_reg <= '0;
			en_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			load_reg <= load_next;
			en_reg <= en_next;
			exp_reg <= exp_next;
		end
	end

	assign enabled = en_reg;
	assign expired = exp_reg;

	AST_WD_ZERO_OFF: assert property (@(posedge clk) disable iff (rst) // [R02]
		arm && !clr && !exp_reg && timeout == WD_DISABLE |=> !en_reg && !exp_reg ##1 !exp_reg)
		else $error("zero timeout did not disable the watchdog");
	AST_WD_RELOAD: assert property (@(posedge clk) disable iff (rst) // [R20]
		kick && !arm && !clr && en_reg && !exp_reg |=> cnt_reg == $past(load_reg) && div_reg == 0)
		else $error("retrigger did not reload the watchdog");
endmodule

// file: src/dpm_host_cmd.sv
// Host command interpreter: watchdog, resets, mode and output image writes.
// Behaviour
// R01 - Watchdog timeout is an unsigned 16-bit count of 10 ms ticks.
// R02 - Arming with zero disables the watchdog, nonzero enables that interval.
// R03 - Host must retrigger before each interval elapses.
// R04 - On expiry the master halts and stops all slave traffic.
// R05 - Halt holds until master or full reset; retrigger does not revive.
// R06 - Arming reports 0 ok, 1 timeout abort, 256 semaphore not set.
// R07 - Retrigger reports 0 ok, nonzero on timeout.
// R08 - Master-only reset keeps the module's register contents.
// R09 - Either reset ends with the master in STOP.
// R10 - Host must not access the master during the reset interval.
// R11 - Full reset reinitialises glue logic and master.
// R12 - Byte sub-channel n is offset n; word sub-channel n is 2n and 2n+1.
// R13 - Host uses station numbers 3 to 123 only.
// R14 - Single writes place one byte or word into the output sub-channel.
// R15 - Block write copies size bytes starting at sub-channel 0 plus offset.
// R16 - Consistent write colliding with an access returns 101; host repeats.
// R17 - Writes return 100 on configuration mismatch, 0 on success.
// R18 - Block write larger than slave buffer returns 102 and does nothing.
// R19 - Master supports CLEAR, STOP, OPERATE and a synchronisation command.
// R20 - Watchdog counts 10 ms ticks, reloaded on retrigger and arming.
// R21 - Writes without consistency never check conflicts nor return 101.
module dpm_host_cmd import dpm_pkg::*; #(
	parameter int BUF_BYTES = BUF_BYTES_DEF,
	parameter int TICK_CYCLES = WD_TICK_CYCLES,
	parameter int RST_CYCLES = RESET_CYCLES
) (
	input wire logic clk, // Module clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic cmd_valid, // Command strobe.
	input wire dpm_cmd_t cmd_code, // Command selector.
	input wire logic cmd_sem, // Command semaphore set by host.
	input wire logic [STATION_W-1:0] cmd_slave, // Station number.
	input wire logic [7:0] cmd_sub, // Sub-channel.
	input wire logic [15:0] cmd_offset, // Block offset on sub-channel 0.
	input wire logic [7:0] cmd_size, // Block size in bytes.
	input wire logic [15:0] cmd_data, // Byte or word datum.
	input wire dpm_mode_t cmd_mode, // Operating mode argument.
	input wire dpm_cons_t cmd_cons, // Consistency option.
	input wire logic blk_valid, // Block byte strobe.
	input wire logic [7:0] blk_byte, // Block byte.
	output logic blk_ready, // Block byte accepted.
	input wire logic [7:0] slave_len, // Configured length of addressed slave.
	input wire logic bus_access_busy, // Bus side is using the image.
	input wire logic [STATION_W+$clog2(BUF_BYTES)-1:0] img_rd_addr, // Image read address.
	output logic [7:0] img_rd_data, // Image read data.
	output logic result_valid, // Result strobe.
	output logic [RES_W-1:0] result_code, // Result code.
	output logic busy, // Block transfer or reset running.
	output dpm_mstate_t master_state, // Master operating state.
	output logic bus_active, // Master exchanges data with slaves.
	output logic sync_pulse, // Synchronisation event.
	output logic glue_reset, // Glue logic held in reset.
	output logic wd_enabled, // Watchdog running.
	output logic wd_expired // Watchdog elapsed.
);
	localparam int OFF_W = $clog2(BUF_BYTES);
	localparam int ADDR_W = STATION_W + OFF_W;
	localparam int DEPTH = BUF_BYTES << STATION_W;
	localparam int RC_W = $clog2(RST_CYCLES + 1);
	localparam logic [RC_W-1:0] RC_LAST = RC_W'(RST_CYCLES - 1);

	if (BUF_BYTES < 256 || (BUF_BYTES & (BUF_BYTES - 1)) != 0 || RST_CYCLES < DEPTH) begin : g_chk
		$error("BUF_BYTES must be a power of two of at least 256, reset must cover the image");
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [ADDR_W-1:0] img_addr(input logic [STATION_W-1:0] st,
		input logic [15:0] off);
		img_addr = {st, off[OFF_W-1:0]}; // [R12]
	endfunction

	function automatic logic station_ok(input logic [STATION_W-1:0] st);
		station_ok = st >= STATION_MIN && st <= STATION_MAX; // [R13]
	endfunction

	function automatic logic [RES_W-1:0] single_res(input logic [15:0] last_off);
		if (!station_ok(cmd_slave) || last_off >= {8'h00, slave_len}) begin
			single_res = RES_BUS_CFG; // [R17]
		end else if (cmd_cons == WITH_CONSISTENCY && bus_access_busy) begin
			single_res = RES_CONS; // [R16] [R21]
		end else begin
			single_res = RES_OK;
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] img [0:DEPTH-1];
	dpm_ctl_t ctl_reg, ctl_next;
	dpm_mstate_t ms_reg, ms_next;
	logic [RC_W-1:0] rc_reg, rc_next;
	logic full_reg, full_next, blk_rdy_reg, blk_rdy_next, rv_reg, rv_next;
	logic sync_reg, sync_next, busy_reg, busy_next, act_reg, act_next;
	logic [RES_W-1:0] res_reg, res_next;
	logic [ADDR_W-1:0] ptr_reg, ptr_next;
	logic [7:0] left_reg, left_next, rd_reg;
	logic wd_arm, wd_kick, wd_clr, wd_en, wd_exp, wr0_en, wr1_en, is_rst;
	logic [ADDR_W-1:0] wr0_addr, wr1_addr;
	logic [7:0] wr0_data, wr1_data;
	logic [16:0] blk_end;

	dpm_wdog #(.TICK_CYCLES(TICK_CYCLES)) u_wdog (
		.clk(clk),
		.rst(rst),
		.arm(wd_arm),
		.timeout(cmd_data),
		.kick(wd_kick),
		.clr(wd_clr),
		.enabled(wd_en),
		.expired(wd_exp)
	);

	assign is_rst = ctl_reg == ST_IDLE && cmd_valid &&
		(cmd_code == MASTER_ONLY_RESET_CMD || cmd_code == FULL_MODULE_RESET_CMD);
	assign blk_end = {1'b0, cmd_offset} + {9'h000, cmd_size};

	// ****************************************************************
	// Command sequencing
	// ****************************************************************
	always_comb begin
		ctl_next = ctl_reg;
		ms_next = ms_reg;
		rc_next = rc_reg;
		full_next = full_reg;
		blk_rdy_next = blk_rdy_reg;
		ptr_next = ptr_reg;
		left_next = left_reg;
		rv_next = 1'b0;
		res_next = res_reg;
		sync_next = 1'b0;
		wd_arm = 1'b0;
		wd_kick = 1'b0;
		wd_clr = 1'b0;
		wr0_en = 1'b0;
		wr0_addr = '0;
		wr0_data = '0;
		wr1_en = 1'b0;
		wr1_addr = '0;
		wr1_data = '0;
		unique case (ctl_reg)
			ST_IDLE: if (cmd_valid) begin
				rv_next = 1'b1;
				res_next = RES_OK;
				unique case (cmd_code)
					ARM_WATCHDOG_CMD: if (!cmd_sem) begin
						res_next = RES_NO_SEM; // [R06]
					end else begin
						wd_arm = 1'b1; // [R01] [R02]
					end
					KICK_WATCHDOG_CMD: if (wd_exp) begin
						res_next = RES_TIMEOUT; // [R05] [R07]
					end else begin
						wd_kick = 1'b1; // [R03]
					end
					MASTER_ONLY_RESET_CMD, FULL_MODULE_RESET_CMD: begin
						ctl_next = ST_RESET;
						ms_next = MS_RESET;
						rc_next = '0;
						wd_clr = 1'b1; // [R05]
						full_next = cmd_code == FULL_MODULE_RESET_CMD; // [R08] [R11]
						rv_next = 1'b0;
					end
					SET_MODE_CMD: if (!cmd_sem) begin
						res_next = RES_NO_SEM;
					end else if (ms_reg == MS_HALTED) begin
						res_next = RES_TIMEOUT; // [R05]
					end else begin
						unique case (cmd_mode) // [R19]
							MODE_CLEAR: ms_next = MS_CLEAR;
							MODE_STOP: ms_next = MS_STOP;
							MODE_OPERATE: ms_next = MS_OPERATE;
							MODE_SYNC: sync_next = 1'b1;
						endcase
					end
					WRITE_OUTPUT_BYTE_CMD: begin
						res_next = single_res({8'h00, cmd_sub}); // [R12]
						wr0_en = res_next == RES_OK; // [R14]
						wr0_addr = img_addr(cmd_slave, {8'h00, cmd_sub});
						wr0_data = cmd_data[7:0];
					end
					WRITE_OUTPUT_WORD_CMD: begin
						res_next = single_res({7'h00, cmd_sub, 1'b1}); // [R12]
						wr0_en = res_next == RES_OK; // [R14]
						wr0_addr = img_addr(cmd_slave, {7'h00, cmd_sub, 1'b0});
						wr0_data = cmd_data[15:8];
						wr1_en = wr0_en;
						wr1_addr = img_addr(cmd_slave, {7'h00, cmd_sub, 1'b1});
						wr1_data = cmd_data[7:0];
					end
					WRITE_OUTPUT_BLOCK_CMD: begin
						if (!station_ok(cmd_slave) || slave_len == 8'h00) begin
							res_next = RES_BUS_CFG; // [R17]
						end else if (blk_end > {9'h000, slave_len}) begin
							res_next = RES_SIZE; // [R18]
						end else if (cmd_cons == WITH_CONSISTENCY && bus_access_busy) begin
							res_next = RES_CONS; // [R16] [R21]
						end else if (cmd_size != 8'h00) begin
							rv_next = 1'b0;
							ctl_next = ST_BLOCK;
							blk_rdy_next = 1'b1;
							ptr_next = img_addr(cmd_slave, cmd_offset); // [R15]
							left_next = cmd_size;
						end
					end
					default: res_next = RES_TIMEOUT;
				endcase
			end
			ST_BLOCK: if (blk_valid && blk_rdy_reg) begin
				wr0_en = 1'b1; // [R15]
				wr0_addr = ptr_reg;
				wr0_data = blk_byte;
				ptr_next = ptr_reg + ADDR_W'(1);
				left_next = left_reg - 8'h01;
				if (left_reg == 8'h01) begin
					blk_rdy_next = 1'b0;
					ctl_next = ST_IDLE;
					rv_next = 1'b1;
					res_next = RES_OK; // [R17]
				end
			end
			ST_RESET: begin
				if (cmd_valid) begin
					rv_next = 1'b1;
					res_next = RES_TIMEOUT; // [R10] [R07]
				end
				if (full_reg && {{(32-RC_W){1'b0}}, rc_reg} < DEPTH) begin
					wr0_en = 1'b1; // [R11]
					wr0_addr = rc_reg[ADDR_W-1:0];
				end
				rc_next = rc_reg + RC_W'(1);
				if (rc_reg == RC_LAST) begin
					ctl_next = ST_IDLE;
					ms_next = MS_STOP; // [R09]
					full_next = 1'b0;
				end
			end
		endcase
		if (wd_exp && ms_next != MS_RESET) begin
			ms_next = MS_HALTED; // [R04]
		end
		busy_next = ctl_next != ST_IDLE;
		act_next = ms_next == MS_CLEAR || ms_next == MS_OPERATE; // [R04]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= ST_IDLE;
			ms_reg <= MS_STOP;
			rc_reg <= '0;
			full_reg <= 1'b0;
			blk_rdy_reg <= 1'b0;
			ptr_reg <= '0;
			left_reg <= '0;
			rv_reg <= 1'b0;
			res_reg <= RES_OK;
			sync_reg <= 1'b0;
			busy_reg <= 1'b0;
			act_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			ms_reg <= ms_next;
			rc_reg <= rc_next;
			full_reg <= full_next;
			blk_rdy_reg <= blk_rdy_next;
			ptr_reg <= ptr_next;
			left_reg <= left_next;
			rv_reg <= rv_next;
			res_reg <= res_next;
			sync_reg <= sync_next;
			busy_reg <= busy_next;
			act_reg <= act_next;
		end
	end

	// Output image; the read port is registered for the bus side.
	always_ff @(posedge clk) begin
		if (wr0_en) begin
			img[wr0_addr] <= wr0_data;
		end
		if (wr1_en) begin
			img[wr1_addr] <= wr1_data;
		end
		rd_reg <= img[img_rd_addr];
	end

	assign blk_ready = blk_rdy_reg;
	assign img_rd_data = rd_reg;
	assign result_valid = rv_reg;
	assign result_code = res_reg;
	assign busy = busy_reg;
	assign master_state = ms_reg;
	assign bus_active = act_reg;
	assign sync_pulse = sync_reg;
	assign glue_reset = full_reg;
	assign wd_enabled = wd_en;
	assign wd_expired = wd_exp;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_HALT_ON_EXPIRY: assert property (@(posedge clk) disable iff (rst) // [R04]
		wd_exp && ctl_reg == ST_IDLE && !is_rst |=> ms_reg == MS_HALTED && !act_reg)
		else $error("watchdog expiry did not halt the master");
	AST_HALT_STICKY: assert property (@(posedge clk) disable iff (rst) // [R05]
		ms_reg == MS_HALTED && !is_rst |=> ms_reg == MS_HALTED)
		else $error("halted master revived without reset");
	AST_RESET_TO_STOP: assert property (@(posedge clk) disable iff (rst) // [R09]
		ctl_reg == ST_RESET && rc_reg == RC_LAST |=> ms_reg == MS_STOP && !busy_reg && !glue_reset)
		else $error("reset did not end in STOP");
	AST_NO_SEM: assert property (@(posedge clk) disable iff (rst) // [R06]
		ctl_reg == ST_IDLE && cmd_valid && cmd_code == ARM_WATCHDOG_CMD && !cmd_sem
		|=> rv_reg && res_reg == RES_NO_SEM)
		else $error("missing semaphore not reported as 256");
	AST_KICK_IN_RESET: assert property (@(posedge clk) disable iff (rst) // [R07]
		ctl_reg == ST_RESET && cmd_valid && cmd_code == KICK_WATCHDOG_CMD
		|=> rv_reg && res_reg != RES_OK)
		else $error("retrigger during reset reported success");
	AST_FULL_GLUE: assert property (@(posedge clk) disable iff (rst) // [R11]
		is_rst && cmd_code == FULL_MODULE_RESET_CMD |=> glue_reset && ms_reg == MS_RESET)
		else $error("full reset did not reset glue logic");
	AST_MASTER_KEEPS: assert property (@(posedge clk) disable iff (rst) // [R08]
		is_rst && cmd_code == MASTER_ONLY_RESET_CMD |=> !glue_reset [*2])
		else $error("master-only reset touched the glue logic");
	AST_NO_CONS_CODE: assert property (@(posedge clk) disable iff (rst) // [R21]
		ctl_reg == ST_IDLE && cmd_valid && cmd_cons == WITHOUT_CONSISTENCY &&
		cmd_code == WRITE_OUTPUT_BYTE_CMD |=> res_reg != RES_CONS)
		else $error("write without consistency reported a conflict");
	AST_BLOCK_SIZE: assert property (@(posedge clk) disable iff (rst) // [R18]
		ctl_reg == ST_IDLE && cmd_valid && cmd_code == WRITE_OUTPUT_BLOCK_CMD &&
		station_ok(cmd_slave) && slave_len != 8'h00 && blk_end > {9'h000, slave_len}
		|=> rv_reg && res_reg == RES_SIZE && ctl_reg == ST_IDLE)
		else $error("oversize block not refused with 102");
	AST_BLOCK_DONE: assert property (@(posedge clk) disable iff (rst) // [R15]
		ctl_reg == ST_BLOCK && blk_valid && blk_rdy_reg && left_reg == 8'h01
		|=> rv_reg && res_reg == RES_OK && !blk_rdy_reg)
		else $error("block write did not finish after the last byte");
endmodule

// file: verif/dpm_host_model.sv
// Host processor model that issues commands and feeds block bytes.
module dpm_host_model import dpm_pkg::*; (
	input wire logic clk, // Module clock.
	output logic cmd_valid, // Command strobe.
	output dpm_cmd_t cmd_code, // Command selector.
	output logic cmd_sem, // Semaphore flag.
	output logic [STATION_W-1:0] cmd_slave, // Station number.
	output logic [7:0] cmd_sub, // Sub-channel.
	output logic [15:0] cmd_offset, // Block offset.
	output logic [7:0] cmd_size, // Block size.
	output logic [15:0] cmd_data, // Datum.
	output dpm_mode_t cmd_mode, // Mode argument.
	output dpm_cons_t cmd_cons, // Consistency option.
	output logic blk_valid, // Block byte strobe.
	output logic [7:0] blk_byte, // Block byte.
	input wire logic result_valid, // Result strobe.
	input wire logic [RES_W-1:0] result_code, // Result code.
	output logic [7:0] slave_len, // Configured slave length.
	output logic bus_access_busy // Bus side conflict.
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmd_valid = 1'b0;
		cmd_code = NO_CMD;
		cmd_sem = 1'b0;
		cmd_slave = 7'h00;
		cmd_sub = 8'h00;
		cmd_offset = 16'h0000;
		cmd_size = 8'h00;
		cmd_data = 16'h0000;
		cmd_mode = MODE_STOP;
		cmd_cons = WITHOUT_CONSISTENCY;
		blk_valid = 1'b0;
		blk_byte = 8'h00;
		slave_len = 8'h10;
		bus_access_busy = 1'b0;
	end

	// The released datum and station number are scrambled so that a late sample shows wrong data.
	task automatic send(input dpm_cmd_t c, input logic [STATION_W-1:0] st, input logic [7:0] sub,
		input logic [15:0] off, input logic [7:0] sz, input logic [15:0] d, input dpm_mode_t m,
		input dpm_cons_t cs, input logic sem);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_slave <= st;
		cmd_sub <= sub;
		cmd_offset <= off;
		cmd_size <= sz;
		cmd_data <= d;
		cmd_mode <= m;
		cmd_cons <= cs;
		cmd_sem <= sem;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_data <= ~d;
		cmd_slave <= ~st;
	endtask

	task automatic get(output logic [RES_W-1:0] r, output logic ok);
		int i;
		ok = 1'b0;
		#1;
		for (i = 0; i < 64; i++) begin
			if (result_valid === 1'b1) begin
				ok = 1'b1;
				break;
			end
			@(posedge clk);
			#1;
		end
		r = result_code;
	endtask

	// Each byte is preceded by one stall cycle.
	task automatic feed(input logic [7:0] first, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			blk_valid <= 1'b0;
			blk_byte <= ~blk_byte;
			@(posedge clk);
			blk_valid <= 1'b1;
			blk_byte <= first + 8'(i);
		end
		@(posedge clk);
		blk_valid <= 1'b0;
		blk_byte <= ~blk_byte;
	endtask

	task automatic cfg(input logic [7:0] len, input logic conflict);
		@(posedge clk);
		slave_len <= len;
		bus_access_busy <= conflict;
	endtask
endmodule

// file: verif/test_dpm_host_cmd.sv
// Self-checking testbench of the host command block.
module test_dpm_host_cmd import dpm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_sem, blk_valid, blk_ready, bus_access_busy, result_valid, busy;
	logic bus_active, sync_pulse, glue_reset, wd_enabled, wd_expired;
	dpm_cmd_t cmd_code;
	dpm_mode_t cmd_mode;
	dpm_cons_t cmd_cons;
	dpm_mstate_t master_state;
	logic [STATION_W-1:0] cmd_slave;
	logic [7:0] cmd_sub, cmd_size, blk_byte, slave_len, img_rd_data;
	logic [15:0] cmd_offset, cmd_data;
	logic [STATION_W+7:0] img_rd_addr = '0;
	logic [RES_W-1:0] result_code;
	dpm_mode_t mode_q = MODE_STOP;
	logic sem_q = 1'b1;
	int mismatches = 0;
	int n_compared = 0;
	int n_sync = 0;

	always #5 clk = ~clk;
	always @(posedge clk) if (sync_pulse === 1'b1) n_sync <= n_sync + 1;

	dpm_host_cmd #(.BUF_BYTES(256), .TICK_CYCLES(4), .RST_CYCLES(32768)) DUT (
		.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sem(cmd_sem),
		.cmd_slave(cmd_slave), .cmd_sub(cmd_sub), .cmd_offset(cmd_offset), .cmd_size(cmd_size),
		.cmd_data(cmd_data), .cmd_mode(cmd_mode), .cmd_cons(cmd_cons), .blk_valid(blk_valid),
		.blk_byte(blk_byte), .blk_ready(blk_ready), .slave_len(slave_len),
		.bus_access_busy(bus_access_busy), .img_rd_addr(img_rd_addr), .img_rd_data(img_rd_data),
		.result_valid(result_valid), .result_code(result_code), .busy(busy),
		.master_state(master_state), .bus_active(bus_active), .sync_pulse(sync_pulse),
		.glue_reset(glue_reset), .wd_enabled(wd_enabled), .wd_expired(wd_expired));

	dpm_host_model HOST (
		.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sem(cmd_sem),
		.cmd_slave(cmd_slave), .cmd_sub(cmd_sub), .cmd_offset(cmd_offset), .cmd_size(cmd_size),
		.cmd_data(cmd_data), .cmd_mode(cmd_mode), .cmd_cons(cmd_cons), .blk_valid(blk_valid),
		.blk_byte(blk_byte), .result_valid(result_valid), .result_code(result_code),
		.slave_len(slave_len), .bus_access_busy(bus_access_busy));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		mismatches++;
		$display("[ERR] %0t %s", $time, what);
		stop_test();
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmd(input dpm_cmd_t c, input logic [6:0] st, input logic [7:0] sub,
		input logic [15:0] d, input dpm_cons_t cs, input logic [RES_W-1:0] exp);
		logic [RES_W-1:0] r;
		logic ok;
		HOST.send(c, st, sub, 16'h0000, 8'h00, d, mode_q, cs, sem_q);
		HOST.get(r, ok);
		if (ok !== 1'b1) hang("no result");
		chk(16'(r), 16'(exp), "result");
	endtask

	task automatic blk(input logic [6:0] st, input logic [15:0] off, input logic [7:0] sz,
		input dpm_cons_t cs, input logic [RES_W-1:0] exp);
		logic [RES_W-1:0] r;
		logic ok;
		HOST.send(WRITE_OUTPUT_BLOCK_CMD, st, 8'h00, off, sz, 16'h0000, mode_q, cs, sem_q);
		if (exp === RES_OK) begin
			#1;
			chk(16'({blk_ready, busy}), 16'h0003, "block start");
			HOST.feed(8'hc0, int'(sz));
		end
		HOST.get(r, ok);
		if (ok !== 1'b1) hang("no block result");
		chk(16'(r), 16'(exp), "block result");
	endtask

	task automatic rd(input logic [6:0] st, input logic [7:0] off, input logic [7:0] exp);
		@(posedge clk);
		img_rd_addr <= {st, off};
		@(posedge clk);
		#1;
		chk(16'(img_rd_data), 16'(exp), "image");
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 40000 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (busy !== 1'b0) hang("busy stuck");
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_write();
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd3, 8'd5, 16'h00a5, WITHOUT_CONSISTENCY, RES_OK);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd123, 8'd15, 16'h003c, WITH_CONSISTENCY, RES_OK);
		cmd(WRITE_OUTPUT_WORD_CMD, 7'd123, 8'd2, 16'h1234, WITH_CONSISTENCY, RES_OK);
		rd(7'd3, 8'd5, 8'ha5);
		rd(7'd123, 8'd4, 8'h12);
		rd(7'd123, 8'd5, 8'h34);
		rd(7'd123, 8'd15, 8'h3c);
	endtask

	task automatic t_err();
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd2, 8'd0, 16'h0011, WITHOUT_CONSISTENCY, RES_BUS_CFG);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd124, 8'd0, 16'h0011, WITHOUT_CONSISTENCY, RES_BUS_CFG);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd3, 8'd16, 16'h0011, WITHOUT_CONSISTENCY, RES_BUS_CFG);
		HOST.cfg(8'h00, 1'b0);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd3, 8'd0, 16'h0011, WITHOUT_CONSISTENCY, RES_BUS_CFG);
		HOST.cfg(8'h10, 1'b1);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd3, 8'd6, 16'h0077, WITH_CONSISTENCY, RES_CONS);
		rd(7'd3, 8'd6, 8'h00);
		cmd(WRITE_OUTPUT_BYTE_CMD, 7'd3, 8'd6, 16'h0077, WITHOUT_CONSISTENCY, RES_OK);
		rd(7'd3, 8'd6, 8'h77);
		HOST.cfg(8'h10, 1'b0);
		cmd(WRITE_OUTPUT_WORD_CMD, 7'd3, 8'd3, 16'h5566, WITH_CONSISTENCY, RES_OK);
		rd(7'd3, 8'd7, 8'h66);
	endtask

	task automatic t_block();
		blk(7'd10, 16'd2, 8'd3, WITH_CONSISTENCY, RES_OK);
		rd(7'd10, 8'd2, 8'hc0);
		rd(7'd10, 8'd4, 8'hc2);
		rd(7'd10, 8'd5, 8'h00);
		blk(7'd10, 16'd14, 8'd3, WITHOUT_CONSISTENCY, RES_SIZE);
		rd(7'd10, 8'd14, 8'h00);
		blk(7'd10, 16'd15, 8'd1, WITHOUT_CONSISTENCY, RES_OK);
		rd(7'd10, 8'd15, 8'hc0);
		HOST.cfg(8'h10, 1'b1);
		blk(7'd10, 16'd0, 8'd2, WITH_CONSISTENCY, RES_CONS);
		HOST.cfg(8'h10, 1'b0);
	endtask

	task automatic t_mode();
		dpm_mode_t m[3] = '{MODE_CLEAR, MODE_STOP, MODE_OPERATE};
		dpm_mstate_t s[3] = '{MS_CLEAR, MS_STOP, MS_OPERATE};
		logic [2:0] b = 3'b101;
		int n = n_sync;
		mode_q = MODE_SYNC;
		cmd(SET_MODE_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_OK);
		repeat (2) @(posedge clk);
		#1;
		chk(16'(n_sync - n), 16'h0001, "sync pulses");
		for (int i = 0; i < 3; i++) begin
			mode_q = m[i];
			cmd(SET_MODE_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_OK);
			@(posedge clk);
			#1;
			chk(16'(master_state), 16'(s[i]), "mode");
			chk(16'(bus_active), 16'(b[i]), "traffic");
		end
	endtask

	task automatic t_wdog();
		int k = 0;
		sem_q = 1'b0;
		cmd(ARM_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0002, WITHOUT_CONSISTENCY, RES_NO_SEM);
		sem_q = 1'b1;
		cmd(ARM_WATCHDOG_CMD, 7'd3, 8'd0, 16'hffff, WITHOUT_CONSISTENCY, RES_OK);
		chk(16'(wd_enabled), 16'h0001, "armed");
		cmd(ARM_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_OK);
		chk(16'(wd_enabled), 16'h0000, "disarmed");
		cmd(ARM_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0002, WITHOUT_CONSISTENCY, RES_OK);
		repeat (4) @(posedge clk);
		cmd(KICK_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_OK);
		while (wd_expired !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(16'(k), 16'd8, "expiry cycles");
		repeat (2) @(posedge clk);
		#1;
		chk(16'(master_state), 16'(MS_HALTED), "halted");
		chk(16'(bus_active), 16'h0000, "traffic stopped");
		cmd(KICK_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_TIMEOUT);
		mode_q = MODE_OPERATE;
		cmd(SET_MODE_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_TIMEOUT);
		chk(16'(master_state), 16'(MS_HALTED), "still halted");
	endtask

	task automatic t_reset(input dpm_cmd_t c, input logic full, input logic [7:0] kept);
		HOST.send(c, 7'd3, 8'd0, 16'h0000, 8'h00, 16'h0000, mode_q, WITHOUT_CONSISTENCY, sem_q);
		#1;
		chk(16'({busy, glue_reset}), 16'({1'b1, full}), "reset start");
		chk(16'(master_state), 16'(MS_RESET), "resetting");
		cmd(KICK_WATCHDOG_CMD, 7'd3, 8'd0, 16'h0000, WITHOUT_CONSISTENCY, RES_TIMEOUT);
		wait_idle();
		chk(16'(master_state), 16'(MS_STOP), "stopped");
		chk(16'({glue_reset, wd_enabled, wd_expired}), 16'h0000, "cleared");
		rd(7'd3, 8'd5, kept);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset(FULL_MODULE_RESET_CMD, 1'b1, 8'h00);
		t_write();
		t_err();
		t_block();
		t_mode();
		t_wdog();
		t_reset(MASTER_ONLY_RESET_CMD, 1'b0, 8'ha5);
		stop_test();
	end
endmodule
